// ### marker_pkg.sv
package marker_pkg;

    // ------------------------------------------------------------
    // register map (word-aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_COUNT  = 4'h8;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_RECV_EN_BIT  = 0;
    localparam int CTRL_MARK_EN_BIT  = 1;
    localparam int CTRL_SYNC_SEL_BIT = 2;
    localparam int CTRL_WIDTH        = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int STAT_SYNC_REQ_BIT = 0;
    localparam int STAT_PAIR_BIT     = 1;
    localparam int STAT_SE_BIT       = 2;

    localparam int CNT_WIDTH = 16;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : marker_pkg

// ### marker_sync2.sv
`timescale 1ns/100ps
module marker_sync2 (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic din,
    input  wire logic rst_val,
    output logic      dout
);
    logic meta_q;
    logic meta_d;
    logic out_q;
    logic out_d;

    always_comb begin
        meta_d = din;
        out_d  = meta_q;
    end

    // reset level of the line is fixed per instance via rst_val tie
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b1;
            out_q  <= 1'b1;
        end else begin
            meta_q <= meta_d;
            out_q  <= out_d;
        end
    end

    assign dout = out_q ^ ~rst_val;
endmodule : marker_sync2

// ### marker_select.sv
`timescale 1ns/100ps
// Overview of operation
// - With sample marking enabled, a rising assertion of the marker pair tags the current sample.
// - With the sync select set, the sync request is taken from the marker pair.
// - The pair may mark samples and carry sync at once, so the sync level feeds the mark path.
// - As sync source the pair is active low; a low level means sync is requested.
// - Without the receiver enable set, the pair is ignored for marking and for sync.
module marker_select
    import marker_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        marker_input_pair,
    input  wire logic        single_ended_sync_pin_n,
    input  wire logic        sample_strobe,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             sync_request,
    output logic             sample_mark,
    output logic             marker_receiver_active
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic pair_s;
    logic se_s_n;

    marker_sync2 u_pair_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .din     (marker_input_pair),
        .rst_val (1'b1),
        .dout    (pair_s)
    );

    marker_sync2 u_se_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .din     (single_ended_sync_pin_n),
        .rst_val (1'b1),
        .dout    (se_s_n)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [CTRL_WIDTH-1:0] ctrl_q;
    logic [CTRL_WIDTH-1:0] ctrl_d;
    logic [CNT_WIDTH-1:0]  mark_cnt_q;
    logic [CNT_WIDTH-1:0]  mark_cnt_d;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic                  wait_q;
    logic                  wait_d;
    logic                  pair_prev_q;
    logic                  pair_prev_d;
    logic                  sync_q;
    logic                  sync_d;
    logic                  mark_q;
    logic                  mark_d;
    logic                  active_q;
    logic                  active_d;

    logic recv_en;
    logic mark_en;
    logic sync_sel;
    logic pair_gated;
    logic mark_event;
    logic access_rd;
    logic access_wr;
    logic wr_ctrl;
    logic wr_count;

    always_comb begin
        recv_en  = ctrl_q[CTRL_RECV_EN_BIT];
        mark_en  = ctrl_q[CTRL_MARK_EN_BIT];
        sync_sel = ctrl_q[CTRL_SYNC_SEL_BIT];
        // disabled receiver reads as idle-high so no edge or request leaks out
        pair_gated = recv_en ? pair_s : 1'b1;
        // reads are taken while waitrequest is high so the data is ready
        // when it drops; writes land only at the edge it is seen low
        access_rd  = avs_read & wait_q;
        access_wr  = avs_write & ~wait_q;
        wr_ctrl    = access_wr & lane0_hit(avs_address, avs_byteenable, ADDR_CTRL);
        wr_count   = access_wr & lane0_hit(avs_address, avs_byteenable, ADDR_COUNT);
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // the control fields live in byte lane 0 and a count clear also needs it, so a write without that lane is dropped
    function automatic logic lane0_hit(
        input logic [3:0] addr,
        input logic [3:0] be,
        input logic [3:0] target
    );
        return (addr == target) && be[0];
    endfunction : lane0_hit

    // ------------------------------------------------------------
    // sync and mark selection
    // ------------------------------------------------------------
    always_comb begin
        if (sync_sel) begin
            sync_d = ~pair_gated;
        end else begin
            sync_d = ~se_s_n;
        end
        // mark path samples the pair itself, whatever it carries, so a sync
        // level on the pair is echoed as marks too
        mark_event  = mark_en & recv_en & pair_gated & ~pair_prev_q;
        mark_d      = mark_event & sample_strobe;
        pair_prev_d = sample_strobe ? pair_gated : pair_prev_q;
        if (!mark_en) begin
            pair_prev_d = pair_gated;
        end
        active_d = recv_en;
    end

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d     = ctrl_q;
        rdata_d    = rdata_q;
        wait_d     = 1'b1;
        mark_cnt_d = mark_cnt_q;
        if (mark_d) begin
            mark_cnt_d = mark_cnt_q + CNT_ONE;
        end
        if ((avs_read | avs_write) && wait_q) begin
            wait_d = 1'b0;
        end
        if (wr_ctrl) begin
            ctrl_d = avs_writedata[CTRL_WIDTH-1:0];
        end
        if (wr_count) begin
            // write clears the mark count; a mark in the same cycle still counts
            mark_cnt_d = mark_d ? CNT_ONE : '0;
        end
        if (access_rd) begin
            case (avs_address)
                ADDR_CTRL: begin
                    rdata_d = {29'h0000_0000, ctrl_q};
                end
                ADDR_STATUS: begin
                    rdata_d = 32'h0000_0000;
                    rdata_d[STAT_SYNC_REQ_BIT] = sync_q;
                    rdata_d[STAT_PAIR_BIT]     = pair_gated;
                    rdata_d[STAT_SE_BIT]       = se_s_n;
                end
                ADDR_COUNT: begin
                    rdata_d = {16'h0000, mark_cnt_q};
                end
                default: begin
                    rdata_d = UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q      <= CTRL_RESET;
            mark_cnt_q  <= '0;
            rdata_q     <= 32'h0000_0000;
            wait_q      <= 1'b1;
            pair_prev_q <= 1'b1;
            sync_q      <= 1'b0;
            mark_q      <= 1'b0;
            active_q    <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            mark_cnt_q  <= mark_cnt_d;
            rdata_q     <= rdata_d;
            wait_q      <= wait_d;
            pair_prev_q <= pair_prev_d;
            sync_q      <= sync_d;
            mark_q      <= mark_d;
            active_q    <= active_d;
        end
    end

    assign avs_readdata           = rdata_q;
    assign avs_waitrequest        = wait_q;
    assign sync_request           = sync_q;
    assign sample_mark            = mark_q;
    assign marker_receiver_active = active_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_sync_from_pair: assert property (@(posedge clk) disable iff (!arst_n)
        (sync_sel && recv_en) |=> (sync_q == ~$past(pair_s)))
        else $error("sync not following pair");
    a_sync_from_pin: assert property (@(posedge clk) disable iff (!arst_n)
        !sync_sel |=> (sync_q == ~$past(se_s_n)))
        else $error("sync not following pin");
    a_pair_low_req: assert property (@(posedge clk) disable iff (!arst_n)
        (sync_sel && recv_en && !pair_s) |=> sync_q)
        else $error("low pair did not request sync");
    a_recv_off_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        (!recv_en && sync_sel) |=> (!sync_q && !mark_q))
        else $error("disabled receiver leaked");
    a_mark_needs_en: assert property (@(posedge clk) disable iff (!arst_n)
        mark_q |-> $past(mark_en && sample_strobe))
        else $error("mark without enable");
    a_mark_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
        (mark_en && recv_en && sample_strobe && pair_s && !pair_prev_q) |=> mark_q)
        else $error("rising marker missed");
    a_shared_echo: assert property (@(posedge clk) disable iff (!arst_n)
        (sync_sel && mark_en && recv_en && sample_strobe && pair_s && !pair_prev_q)
        |=> (mark_q && !sync_q))
        else $error("sync release not echoed as mark");
    a_bus_answer: assert property (@(posedge clk) disable iff (!arst_n)
        ((avs_read || avs_write) && wait_q) |=> !wait_q ##1 wait_q)
        else $error("bus answer timing wrong");

    a_wait_idle_high: assert property (@(posedge clk) disable iff (!arst_n)
        (!(avs_read || avs_write) && wait_q) |=> wait_q)
        else $error("waitrequest dropped without request");

    a_ctrl_write_lands: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl |=> (ctrl_q == $past(avs_writedata[CTRL_WIDTH-1:0])))
        else $error("control write lost");

    a_mark_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
        mark_q |=> !mark_q)
        else $error("mark pulse longer than one cycle");

    a_active_follows: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> (active_q == $past(recv_en)))
        else $error("receiver active flag wrong");

    a_pair_high_idle: assert property (@(posedge clk) disable iff (!arst_n)
        (sync_sel && recv_en && pair_s) |=> !sync_q)
        else $error("high pair requested sync");

    a_pin_idle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        (!sync_sel && se_s_n) |=> !sync_q)
        else $error("idle pin requested sync");

    a_count_on_mark: assert property (@(posedge clk) disable iff (!arst_n)
        (mark_d && !wr_count) |=> (mark_cnt_q == $past(mark_cnt_q) + CNT_ONE))
        else $error("mark not counted");

    a_count_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (!mark_d && !wr_count) |=> $stable(mark_cnt_q))
        else $error("mark count moved without mark");

    a_count_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_count && !mark_d) |=> (mark_cnt_q == '0))
        else $error("count write did not clear");

    a_mark_off_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        !recv_en |=> !mark_q)
        else $error("mark with receiver off");

endmodule : marker_select

// ### marker_link_rx.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// far-end link logic: drives the marker pair as sync request
// ------------------------------------------------------------
module marker_link_rx (
    input  wire logic clk,
    input  wire logic sync_req,
    output logic      marker_input_pair
);
    // idle high at time zero so the pair never floats unknown
    initial marker_input_pair = 1'b1;
    always @(posedge clk) begin
        marker_input_pair <= ~sync_req;
    end
endmodule : marker_link_rx

// ### timestamp_sync_input_select_tb.sv
`timescale 1ns/100ps
module timestamp_sync_input_select_tb;
    import marker_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, pin_n = 1'b1, strobe = 1'b0, req = 1'b0;
    logic        rd = 1'b0, wr = 1'b0, pair, wait_q, sync_req, mark, active;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    int          fails = 0, check_count = 0, cyc = 0, seen = 0, exp_cnt = 0;
    int          r, en, mk, sel, prev, gp;
    // ------------------------------------------------------------
    // clock, design, far side
    // ------------------------------------------------------------
    always #25 clk = ~clk;
    marker_select u_marker_select (.clk(clk), .arst_n(arst_n), .marker_input_pair(pair),
        .single_ended_sync_pin_n(pin_n), .sample_strobe(strobe), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
        .avs_readdata(rdata), .avs_waitrequest(wait_q), .sync_request(sync_req),
        .sample_mark(mark), .marker_receiver_active(active));
    marker_link_rx u_marker_link_rx (.clk(clk), .sync_req(req), .marker_input_pair(pair));
    always @(posedge clk) begin
        cyc++;
        if (mark === 1'b1) seen++;
        if (cyc > 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_q !== 1'b0 && n < 50);
        if (n >= 50) fails++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    initial begin
        void'($urandom(32'h08f81a0d));
        idle(8);
        arst_n <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(q, {29'h0, CTRL_RESET});
        bus(1'b0, 4'hC, 32'h0);
        chk(q, UNMAPPED_READ);
        en = 0;
        prev = 1;
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            en = r[0];
            mk = r[1];
            sel = r[2];
            bus(1'b1, ADDR_CTRL, {29'h0, r[2:0]});
            @(posedge clk);
            req <= r[3];
            pin_n <= r[4];
            idle(7);
            gp = en ? !r[3] : 1;
            // rising gated pair between strobes tags the sample
            if (en && mk && !prev && gp) exp_cnt++;
            prev = gp;
            strobe <= 1'b1;
            @(posedge clk);
            strobe <= 1'b0;
            idle(3);
            chk(seen, exp_cnt);
            chk(sync_req, sel ? (en && r[3]) : !r[4]);
            chk(active, en[0]);
            bus(1'b0, ADDR_STATUS, 32'h0);
            chk(q[STAT_SYNC_REQ_BIT], sel ? (en && r[3]) : !r[4]);
            bus(1'b0, ADDR_COUNT, 32'h0);
            chk(q, exp_cnt);
        end
        bus(1'b1, ADDR_COUNT, 32'h0);
        bus(1'b0, ADDR_COUNT, 32'h0);
        chk(q, 32'h0);
        stop_test();
    end
endmodule : timestamp_sync_input_select_tb
